// ---- design/tmr_pkg.sv ----
package tmr_pkg;

  // register word indices (printed offsets are not all multiples of four,
  // so each printed offset is an index and the byte address is four times it)
  localparam logic [7:0] IDX_INTERRUPT_CONTROL  = 8'h0b;
  localparam logic [7:0] IDX_PERIPHERAL_FLAGS   = 8'h0c;
  localparam logic [7:0] IDX_COUNT_LOW_BYTE     = 8'h0e;
  localparam logic [7:0] IDX_COUNT_HIGH_BYTE    = 8'h0f;
  localparam logic [7:0] IDX_TIMER_CONTROL      = 8'h10;
  localparam logic [7:0] IDX_PERIPHERAL_ENABLES = 8'h8c;
  localparam logic [7:0] IDX_SYSTEM_STATUS      = 8'h20;
  localparam logic [7:0] IDX_OSC_PORT_VIEW      = 8'h21;

  // timer_control fields
  localparam int TC_TIMER_ON     = 0;
  localparam int TC_CLOCK_SOURCE = 1;
  localparam int TC_NO_SYNC_N    = 2;
  localparam int TC_CRYSTAL_OSC  = 3;
  localparam int TC_PRESCALE_LO  = 4;
  localparam int TC_GATE_ENABLE  = 6;
  localparam logic [7:0] TC_WRITE_MASK = 8'h7f;

  // interrupt_control / peripheral_flags / peripheral_enables fields
  localparam int IC_GLOBAL_EN     = 7;
  localparam int IC_PERIPHERAL_EN = 6;
  localparam int PF_OVERFLOW      = 0;
  localparam int PE_OVERFLOW_EN   = 0;

  // osc_port_view fields
  localparam int OV_PIN_B      = 0;
  localparam int OV_PIN_A      = 1;
  localparam int OV_DIR_B      = 2;
  localparam int OV_DIR_A      = 3;

  localparam logic [7:0]  RESET_BYTE = 8'h00;
  localparam logic [15:0] COUNT_MAX  = 16'hffff;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;

  typedef struct packed {
    logic       gate_enable;
    logic [1:0] prescale_sel;
    logic       crystal_osc_enable;
    logic       no_sync_n;
    logic       clock_source_select;
    logic       timer_on;
  } ctrl_s;

endpackage

// ---- design/gated_timer.sv ----
`timescale 1ns/1ns
`default_nettype none

// How it works
// - internal source: count advances each instruction cycle after prescaling
// - external source: count advances on rising edges of the clock pin
// - external mode counts no rising edge before a falling edge is seen
// - with gate enabled and timer on, counting only while gate pin low
// - count rollover from all ones to zero sets the overflow flag
// - interrupt needs flag, timer enable, peripheral enable and global enable
// - prescaler divides the count clock by 1, 2, 4 or 8
// - prescaler is hidden and is cleared by a write of either count byte
// - crystal enable works only while on internal oscillator
// - external source: pin synchronised either way; no_sync_n set lets it count in sleep
// - timer_on set lets the timer run, clear stops counting
// - asynchronous counter mode keeps counting in sleep and wakes on overflow
// - only async mode counts in sleep; wake needs on and both enables
// - count byte reads always return a whole, clean byte value
// - crystal on (enable set, internal osc) forces osc pin directions to one, port bits to zero
// - crystal usable as source only when system runs from internal osc
module gated_timer (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        soft_rst,
  input  wire logic        sleep_mode,
  input  wire logic        on_internal_osc,
  input  wire logic        ext_count_clock_pin,
  input  wire logic        count_gate_n,
  input  wire logic        osc_pin_a,
  input  wire logic        osc_pin_b,
  input  wire logic        osc_pin_a_direction,
  input  wire logic        osc_pin_b_direction,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             irq,
  output logic             wake,
  output logic             crystal_osc_on,
  output logic             view_pin_a,
  output logic             view_pin_b,
  output logic             view_dir_a,
  output logic             view_dir_b
);

  tmr_pkg::ctrl_s ctrl_r;
  logic [15:0]    count_r;
  logic [2:0]     presc_r;
  logic           flag_r;
  logic           tie_r;
  logic           glb_en_r;
  logic           per_en_r;
  logic           ovf_en_r;
  logic [2:0]     ck_sync_r;
  logic [2:0]     gt_sync_r;
  logic           ck_last_r;
  logic           fall_seen_r;
  logic           wr_pend_r;
  logic [7:0]     wr_idx_r;
  logic           rd_pend_r;
  logic [7:0]     rd_idx_r;

  // --- AHB-Lite slave: zero wait states, OKAY only ---
  logic       addr_ok;
  logic [7:0] a_idx;
  assign a_idx   = haddr[9:2];
  assign addr_ok = hsel && hready && htrans == tmr_pkg::HTRANS_NONSEQ;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      wr_idx_r  <= 8'h00;
      rd_idx_r  <= 8'h00;
    end else if (clk_en) begin
      wr_pend_r <= addr_ok && hwrite;
      rd_pend_r <= addr_ok && !hwrite;
      if (addr_ok) begin
        wr_idx_r <= a_idx;
        rd_idx_r <= a_idx;
      end
    end
  end

  logic wr_ctrl;
  logic wr_lo;
  logic wr_hi;
  logic wr_flags;
  logic wr_ic;
  logic wr_pe;
  assign wr_ctrl  = wr_pend_r && wr_idx_r == tmr_pkg::IDX_TIMER_CONTROL;
  assign wr_lo    = wr_pend_r && wr_idx_r == tmr_pkg::IDX_COUNT_LOW_BYTE;
  assign wr_hi    = wr_pend_r && wr_idx_r == tmr_pkg::IDX_COUNT_HIGH_BYTE;
  assign wr_flags = wr_pend_r && wr_idx_r == tmr_pkg::IDX_PERIPHERAL_FLAGS;
  assign wr_ic    = wr_pend_r && wr_idx_r == tmr_pkg::IDX_INTERRUPT_CONTROL;
  assign wr_pe    = wr_pend_r && wr_idx_r == tmr_pkg::IDX_PERIPHERAL_ENABLES;

  // --- pin synchronisers: change accepted when stages 2 and 3 agree ---
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ck_sync_r <= 3'h0;
      gt_sync_r <= 3'h7;
    end else if (clk_en) begin
      ck_sync_r <= {ck_sync_r[1:0], ext_count_clock_pin};
      gt_sync_r <= {gt_sync_r[1:0], count_gate_n};
    end
  end

  logic ck_lvl;
  logic gate_open;
  logic gate_lvl_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ck_last_r  <= 1'b0;
      gate_lvl_r <= 1'b1;
    end else if (clk_en) begin
      if (ck_sync_r[1] == ck_sync_r[2])
        ck_last_r <= ck_sync_r[2];
      if (gt_sync_r[1] == gt_sync_r[2])
        gate_lvl_r <= gt_sync_r[2];
    end
  end
  // new accepted clock level this cycle
  assign ck_lvl = (ck_sync_r[1] == ck_sync_r[2]) ? ck_sync_r[2] : ck_last_r;

  logic ext_rise;
  logic ext_fall;
  assign ext_rise = ck_lvl && !ck_last_r;
  assign ext_fall = !ck_lvl && ck_last_r;

  // one sampling path serves both sync and async modes: the pin is foreign
  // to sys_clk either way, so no_sync_n only decides sleep behaviour
  logic async_mode;
  assign async_mode = ctrl_r.clock_source_select && ctrl_r.no_sync_n;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      fall_seen_r <= 1'b0;
    else if (clk_en) begin
      if (!ctrl_r.clock_source_select || !ctrl_r.timer_on)
        fall_seen_r <= 1'b0;
      else if (ext_fall)
        fall_seen_r <= 1'b1;
    end
  end

  logic src_tick;
  always_comb begin
    if (ctrl_r.clock_source_select)
      src_tick = ext_rise && fall_seen_r;
    else
      src_tick = !sleep_mode;
  end

  assign gate_open = !ctrl_r.gate_enable || !gate_lvl_r;

  logic run;
  assign run = ctrl_r.timer_on && gate_open &&
               (!sleep_mode || async_mode);

  logic [2:0] presc_mask;
  always_comb begin
    case (ctrl_r.prescale_sel)
      2'b00:   presc_mask = 3'h0;
      2'b01:   presc_mask = 3'h1;
      2'b10:   presc_mask = 3'h3;
      2'b11:   presc_mask = 3'h7;
      default: presc_mask = 3'h0;
    endcase
  end

  logic presc_done;
  assign presc_done = (presc_r & presc_mask) == presc_mask;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      presc_r <= 3'h0;
    else if (clk_en) begin
      if (wr_lo || wr_hi)
        presc_r <= 3'h0;
      else if (run && src_tick)
        presc_r <= presc_done ? 3'h0 : presc_r + 3'h1;
    end
  end

  logic inc;
  logic rollover;
  assign inc      = run && src_tick && presc_done && !wr_lo && !wr_hi;
  assign rollover = inc && count_r == tmr_pkg::COUNT_MAX;

  // count and control survive soft resets; only rst clears them
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      count_r <= 16'h0000;
    else if (clk_en) begin
      if (wr_lo)
        count_r[7:0] <= hwdata[7:0];
      else if (wr_hi)
        count_r[15:8] <= hwdata[7:0];
      else if (inc)
        count_r <= count_r + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      ctrl_r <= '0;
    else if (clk_en && wr_ctrl)
      ctrl_r <= hwdata[6:0] & tmr_pkg::TC_WRITE_MASK[6:0];
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      flag_r <= 1'b0;
    else if (clk_en) begin
      if (rollover)
        flag_r <= 1'b1;
      else if (wr_flags)
        flag_r <= hwdata[tmr_pkg::PF_OVERFLOW];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      glb_en_r <= 1'b0;
      per_en_r <= 1'b0;
      ovf_en_r <= 1'b0;
    end else if (clk_en) begin
      if (soft_rst) begin
        glb_en_r <= 1'b0;
        per_en_r <= 1'b0;
        ovf_en_r <= 1'b0;
      end else begin
        if (wr_ic) begin
          glb_en_r <= hwdata[tmr_pkg::IC_GLOBAL_EN];
          per_en_r <= hwdata[tmr_pkg::IC_PERIPHERAL_EN];
        end
        if (wr_pe)
          ovf_en_r <= hwdata[tmr_pkg::PE_OVERFLOW_EN];
      end
    end
  end
  assign tie_r = ovf_en_r;

  assign irq  = flag_r && tie_r && per_en_r && glb_en_r;
  assign wake = sleep_mode && flag_r && tie_r && per_en_r &&
                ctrl_r.timer_on && async_mode;

  assign crystal_osc_on = ctrl_r.crystal_osc_enable &&
                          on_internal_osc;
  assign view_pin_a = crystal_osc_on ? 1'b0 : osc_pin_a;
  assign view_pin_b = crystal_osc_on ? 1'b0 : osc_pin_b;
  assign view_dir_a = crystal_osc_on ? 1'b1 : osc_pin_a_direction;
  assign view_dir_b = crystal_osc_on ? 1'b1 : osc_pin_b_direction;

  // reads sample the sys_clk-domain count, so bytes never tear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      hrdata <= 32'h0000_0000;
    else if (clk_en && addr_ok && !hwrite) begin
      case (a_idx)
        tmr_pkg::IDX_COUNT_LOW_BYTE:  hrdata <= {24'h0, count_r[7:0]};
        tmr_pkg::IDX_COUNT_HIGH_BYTE: hrdata <= {24'h0, count_r[15:8]};
        tmr_pkg::IDX_TIMER_CONTROL:   hrdata <= {25'h0, ctrl_r};
        tmr_pkg::IDX_PERIPHERAL_FLAGS:   hrdata <= {31'h0, flag_r};
        tmr_pkg::IDX_PERIPHERAL_ENABLES: hrdata <= {31'h0, ovf_en_r};
        tmr_pkg::IDX_INTERRUPT_CONTROL:
          hrdata <= {24'h0, glb_en_r, per_en_r, 6'h0};
        tmr_pkg::IDX_SYSTEM_STATUS:
          hrdata <= {29'h0, wake, irq, crystal_osc_on};
        tmr_pkg::IDX_OSC_PORT_VIEW:
          hrdata <= {28'h0, view_dir_a, view_dir_b, view_pin_a, view_pin_b};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------- assertions ----------------
  AST_IRQ_AND: assert property (
    @(posedge sys_clk) disable iff (rst)
    irq == (flag_r && ovf_en_r && per_en_r && glb_en_r))
    else $error("irq not the and of its enables");

  AST_ROLL_SETS_FLAG: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && rollover |=> flag_r && count_r == 16'h0000)
    else $error("rollover did not set flag");

  AST_FLAG_STICKY: assert property (
    @(posedge sys_clk) disable iff (rst)
    flag_r && !(clk_en && wr_flags) |=> flag_r)
    else $error("flag cleared by hardware");

  AST_OFF_HOLDS: assert property (
    @(posedge sys_clk) disable iff (rst)
    !ctrl_r.timer_on && !(wr_lo || wr_hi) |=> $stable(count_r))
    else $error("count moved while timer off");

  AST_GATE_HOLDS: assert property (
    @(posedge sys_clk) disable iff (rst)
    ctrl_r.gate_enable && gate_lvl_r && !(wr_lo || wr_hi)
    |=> $stable(count_r))
    else $error("count moved while gated");

  AST_PRESC_CLR: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && (wr_lo || wr_hi) |=> presc_r == 3'h0)
    else $error("prescaler not cleared on count write");

  AST_NO_EARLY_EDGE: assert property (
    @(posedge sys_clk) disable iff (rst)
    ctrl_r.clock_source_select && !fall_seen_r && !(wr_lo || wr_hi)
    |=> $stable(count_r))
    else $error("counted before falling edge");

  // a stopped timer forgets the falling edge, so each start needs a new one
  AST_FALL_CLEARED: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && !ctrl_r.timer_on |=> !fall_seen_r)
    else $error("falling edge memory kept while timer off");

  AST_DIV1_TIMER: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && ctrl_r.timer_on && !ctrl_r.clock_source_select &&
    !ctrl_r.gate_enable && !sleep_mode && ctrl_r.prescale_sel == 2'b00 &&
    !(wr_lo || wr_hi) && !wr_ctrl |=> count_r == $past(count_r) + 16'h0001)
    else $error("divide-by-1 timer did not step");

  AST_DIV8_STEP: assert property (
    @(posedge sys_clk) disable iff (rst)
    inc && ctrl_r.prescale_sel == 2'b11 |-> presc_r == 3'h7)
    else $error("divide-by-8 stepped early");

  AST_SLEEP_SYNC: assert property (
    @(posedge sys_clk) disable iff (rst)
    sleep_mode && !async_mode && !(wr_lo || wr_hi) |=> $stable(count_r))
    else $error("counted in sleep outside async mode");

  AST_WAKE_ASYNC: assert property (
    @(posedge sys_clk) disable iff (rst)
    wake |-> sleep_mode && async_mode && ctrl_r.timer_on && per_en_r)
    else $error("wake outside asynchronous counter mode");

  AST_SOFT_KEEPS: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && soft_rst && !wr_ctrl |=> $stable(ctrl_r))
    else $error("soft reset disturbed the control register");

  AST_OSC_VIEW: assert property (
    @(posedge sys_clk) disable iff (rst)
    crystal_osc_on |-> view_dir_a && view_dir_b && !view_pin_a && !view_pin_b)
    else $error("oscillator pin view not forced");

  AST_OSC_GATED: assert property (
    @(posedge sys_clk) disable iff (rst)
    !on_internal_osc |-> !crystal_osc_on)
    else $error("crystal on without internal oscillator");

  COV_ROLLOVER: cover property (@(posedge sys_clk) disable iff (rst)
    rollover);
  COV_IRQ: cover property (@(posedge sys_clk) disable iff (rst) irq);
  COV_WAKE: cover property (@(posedge sys_clk) disable iff (rst) wake);
  COV_EXT_INC: cover property (@(posedge sys_clk) disable iff (rst)
    inc && ctrl_r.clock_source_select);

endmodule

`default_nettype wire

// ---- verif/ext_clk_src.sv ----
`timescale 1ns/1ns
`default_nettype none
// far-side clock source: a burst of pulses 4 cycles high, 4 low; it idles
// low, so the first rise of a burst has no fall before it
module ext_clk_src (
  input  wire logic       sys_clk,
  input  wire logic       start,
  input  wire logic [7:0] pulses,
  output logic            ext_count_clock_pin
);
  logic [7:0] left_r;
  logic [2:0] ph_r;
  initial begin
    ext_count_clock_pin = 1'b0;
    left_r = 8'h00;
    ph_r = 3'h0;
  end
  always @(posedge sys_clk) begin
    ph_r <= start ? 3'h0 : ph_r + 3'h1;
    if (start) begin
      left_r <= pulses;
    end else if (left_r != 8'h00 && ph_r == 3'h7) begin
      left_r <= left_r - 8'h01;
    end
    ext_count_clock_pin <= !start && left_r != 8'h00 && !ph_r[2];
  end
endmodule
`default_nettype wire

// ---- verif/gated_16bit_timer_counter_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module gated_16bit_timer_counter_tb;
  localparam logic [7:0] ICTL = tmr_pkg::IDX_INTERRUPT_CONTROL;
  localparam logic [7:0] PFLG = tmr_pkg::IDX_PERIPHERAL_FLAGS;
  localparam logic [7:0] CLO  = tmr_pkg::IDX_COUNT_LOW_BYTE;
  localparam logic [7:0] CHI  = tmr_pkg::IDX_COUNT_HIGH_BYTE;
  localparam logic [7:0] TCTL = tmr_pkg::IDX_TIMER_CONTROL;
  localparam logic [7:0] PENA = tmr_pkg::IDX_PERIPHERAL_ENABLES;
  logic        sys_clk, rst, soft_rst, sleep_mode, on_internal_osc;
  logic        ext_count_clock_pin, count_gate_n, start;
  logic        osc_pin_a, osc_pin_b, osc_pin_a_direction, osc_pin_b_direction;
  logic        hsel, hwrite, hreadyout, hresp, irq, wake, crystal_osc_on;
  logic        view_pin_a, view_pin_b, view_dir_a, view_dir_b;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [15:0] a, b, c;
  int          fails, total_checks, i;

  gated_timer uut (
    .sys_clk, .rst, .clk_en(1'b1), .soft_rst, .sleep_mode, .on_internal_osc,
    .ext_count_clock_pin, .count_gate_n, .osc_pin_a, .osc_pin_b,
    .osc_pin_a_direction, .osc_pin_b_direction, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .irq, .wake, .crystal_osc_on, .view_pin_a, .view_pin_b,
    .view_dir_a, .view_dir_b
  );
  ext_clk_src far (.sys_clk, .start, .pulses(8'h05), .ext_count_clock_pin);

  task automatic complete_run();
    if (fails == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_ready();
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk);
      if (hreadyout === 1'b1) return;
    end
    fails++;
    complete_run();
  endtask
  // called just after a rising edge; returns just after the closing edge
  task automatic bus(input logic [7:0] idx, input logic w,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= w;
    htrans <= tmr_pkg::HTRANS_NONSEQ;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(idx, 1'b1, {24'h0, d}, q);
  endtask
  task automatic rdc(input string what, input logic [7:0] idx,
                     input logic [31:0] exp);
    logic [31:0] q;
    bus(idx, 1'b0, 32'h0, q);
    check(what, q, exp);
  endtask
  // the timer is stopped first, so no carry falls between the reads
  task automatic rd16(output logic [15:0] v);
    logic [31:0] lo, hi;
    bus(CLO, 1'b0, 32'h0, lo);
    bus(CHI, 1'b0, 32'h0, hi);
    v = {hi[7:0], lo[7:0]};
  endtask
  // loading the count also clears the prescaler, so runs start in phase
  task automatic run(input logic [7:0] tc, input logic [15:0] init,
                     input int cyc, input logic ext, output logic [15:0] v);
    wr(CLO, init[7:0]);
    wr(CHI, init[15:8]);
    wr(TCTL, tc);
    start <= ext;
    @(posedge sys_clk);
    start <= 1'b0;
    repeat (cyc) @(posedge sys_clk);
    wr(TCTL, 8'h00);
    rd16(v);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial begin
    {rst, soft_rst, sleep_mode, on_internal_osc, start} = 5'b10000;
    {count_gate_n, osc_pin_a, osc_pin_b} = 3'b111;
    {osc_pin_a_direction, osc_pin_b_direction, hsel, hwrite} = 4'h0;
    htrans = 2'h0;
    hsize = tmr_pkg::HSIZE_WORD;
    haddr = 32'h0;
    hwdata = 32'h0;
    fails = 0;
    total_checks = 0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rdc("ictl", ICTL, 32'h0);
    rdc("pflg", PFLG, 32'h0);
    rdc("tctl", TCTL, 32'h0);
    rdc("pena", PENA, 32'h0);
    wr(8'h55, 8'hff);
    rdc("unmapped", 8'h55, 32'h0);
    check("hresp", {31'h0, hresp}, 32'h0);
    wr(TCTL, 8'hff);
    rdc("tctl mask", TCTL, 32'h7f);
    wr(TCTL, 8'h00);
    run(8'h00, 16'h0, 64, 1'b0, a);
    check("off", 32'(a), 32'h0);
    for (i = 0; i < 4; i++) begin
      run({2'b00, 2'(i), 4'h1}, 16'h0, 1, 1'b0, a);
      run({2'b00, 2'(i), 4'h1}, 16'h0, 65, 1'b0, b);
      check("prescale", 32'(b - a), 32'(64 >> i));
    end
    run(8'h41, 16'h0, 64, 1'b0, a);
    check("gate high", 32'(a), 32'h0);
    run(8'h01, 16'h0, 64, 1'b0, c);
    count_gate_n <= 1'b0;
    run(8'h41, 16'h0, 64, 1'b0, b);
    check("gate low", 32'(b), 32'(c));
    wr(PFLG, 8'h00);
    wr(PENA, 8'h01);
    wr(ICTL, 8'hc0);
    run(8'h01, 16'hfffe, 8, 1'b0, a);
    check("wrap", 32'(a), 32'h9);
    rdc("flag", PFLG, 32'h1);
    #1 check("irq on", {31'h0, irq}, 32'h1);
    wr(ICTL, 8'h40);
    #1 check("irq no global", {31'h0, irq}, 32'h0);
    wr(ICTL, 8'hc0);
    wr(PENA, 8'h00);
    #1 check("irq no enable", {31'h0, irq}, 32'h0);
    rdc("flag kept", PFLG, 32'h1);
    wr(PFLG, 8'h00);
    wr(PENA, 8'h01);
    #1 check("irq cleared", {31'h0, irq}, 32'h0);
    run(8'h03, 16'h0, 60, 1'b1, a);
    check("ext sync", 32'(a), 32'h4);
    run(8'h07, 16'h0, 60, 1'b1, a);
    check("ext async", 32'(a), 32'h4);
    sleep_mode <= 1'b1;
    run(8'h01, 16'h0, 64, 1'b0, a);
    check("sleep int", 32'(a), 32'h0);
    run(8'h03, 16'h0, 60, 1'b1, a);
    check("sleep sync", 32'(a), 32'h0);
    wr(ICTL, 8'h40);
    run(8'h07, 16'hfffe, 60, 1'b1, a);
    check("sleep async", 32'(a), 32'h2);
    wr(TCTL, 8'h07);
    #1 check("wake", {30'h0, wake, irq}, 32'h2);
    wr(TCTL, 8'h00);
    sleep_mode <= 1'b0;
    wr(PFLG, 8'h00);
    on_internal_osc <= 1'b1;
    wr(TCTL, 8'h08);
    #1 check("xtal", {27'h0, crystal_osc_on, view_dir_a, view_dir_b,
                      view_pin_a, view_pin_b}, 32'h1c);
    rdc("status", tmr_pkg::IDX_SYSTEM_STATUS, 32'h1);
    rdc("pin view", tmr_pkg::IDX_OSC_PORT_VIEW, 32'hc);
    on_internal_osc <= 1'b0;
    @(posedge sys_clk);
    #1 check("no xtal", {27'h0, crystal_osc_on, view_dir_a, view_dir_b,
                         view_pin_a, view_pin_b}, 32'h03);
    wr(TCTL, 8'h30);
    wr(CLO, 8'h34);
    wr(CHI, 8'h12);
    soft_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    soft_rst <= 1'b0;
    rdc("tctl kept", TCTL, 32'h30);
    rdc("low kept", CLO, 32'h34);
    rdc("high kept", CHI, 32'h12);
    rdc("ictl soft", ICTL, 32'h0);
    rdc("pena soft", PENA, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
